// ===== src/eerd_top.sv
// two-wire serial eeprom slave: addressing, reads, page buffer, write protect
//
// Summary of operation
// - busy write cycle ignores array reads and writes
// - no device acknowledge until write cycle ends
// - protect high blocks writes to 1800h-1FFFh
// - protect low leaves whole array writable
// - protect level taken at stop, later ignored
// - protected write acked, no cycle, ready at once
// - word counter holds last address plus one, rolling within the page after writes
// - read increment past top wraps to zero
// - current read acks then sends counter byte
// - master nack on ninth clock ends read
// - after dummy write, read returns loaded address
// - each master ack increments and sends next
// - array powers up holding all ones
// - address byte 1010, strap bits, then direction
// - two word bytes carry thirteen-bit address
module eerd_top #(
  parameter int unsigned WRITE_CYCLES = eerd_pkg::WRITE_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // two-wire bus, data open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and protect
  input wire logic [2:0] strap,
  input wire logic wp_in,
  // status
  output logic write_busy
);
  localparam int AW = eerd_pkg::ADDR_W;

  logic scl_s, sda_s, wp_s;
  logic [2:0] strap_s;
  logic scl_d, sda_d;
  eerd_pkg::eerd_state_t state, ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [4:0] addr_hi;
  logic [AW-1:0] word_addr;
  logic [AW-6:0] page_row;
  logic [7:0] pbuf [eerd_pkg::PAGE_BYTES];
  logic [eerd_pkg::PAGE_BYTES-1:0] pmask;
  logic pend;
  logic [7:0] mem [eerd_pkg::MEM_BYTES];
  logic [eerd_pkg::WR_CNT_W-1:0] wr_cnt;
  logic [7:0] rd_word;
  logic scl_rise, scl_fall, start_c, stop_c, blocked, commit, byte_end, load_ev;

  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] s);
    return (b[7:4] == eerd_pkg::DEV_TYPE) && (b[3:1] == s);
  endfunction

  function automatic logic in_upper(input logic [AW-6:0] row);
    return row[AW-6 -: 2] == eerd_pkg::PROT_QUAD;
  endfunction

  eerd_sync #(.W(2), .INIT(2'b11)) u_bus_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin({scl_in, sda_in}),
    .level({scl_s, sda_s})
  );

  eerd_sync #(.W(4), .INIT(4'h0)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin({wp_in, strap}),
    .level({wp_s, strap_s})
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = ce & scl_s & ~scl_d;
  assign scl_fall = ce & ~scl_s & scl_d;
  assign start_c = ce & scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = ce & scl_s & scl_d & ~sda_d & sda_s;
  assign rd_word = mem[word_addr];
  assign byte_end = scl_fall && !start_c && !stop_c && (bit_cnt == eerd_pkg::BYTE_BITS);
  assign load_ev = !start_c && !stop_c && scl_fall
                   && ((state == eerd_pkg::S_ACK && ack_next == eerd_pkg::S_RDAT)
                       || state == eerd_pkg::S_MACK);
  // protect level is looked at only here, at the stop itself
  assign blocked = wp_s && in_upper(page_row);
  assign commit = stop_c && pend && !blocked;

  // bus protocol and address counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eerd_pkg::S_IDLE;
      ack_next <= eerd_pkg::S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      addr_hi <= 5'h00;
      word_addr <= '0;
      page_row <= '0;
      pmask <= '0;
      pend <= 1'b0;
      sda_oe <= 1'b0;
      for (int i = 0; i < eerd_pkg::PAGE_BYTES; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (ce) begin
      if (start_c) begin
        // repeated start drops an unfinished data phase: dummy write
        state <= eerd_pkg::S_DEV;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        pend <= 1'b0;
      end else if (stop_c) begin
        state <= eerd_pkg::S_IDLE;
        sda_oe <= 1'b0;
        pend <= 1'b0;
      end else begin
        case (state)
          eerd_pkg::S_DEV, eerd_pkg::S_AHI, eerd_pkg::S_ALO, eerd_pkg::S_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_end) begin
              bit_cnt <= 4'h0;
              state <= eerd_pkg::S_ACK;
              sda_oe <= 1'b1;
              case (state)
                eerd_pkg::S_DEV: begin
                  if (!addr_match(shreg, strap_s) || write_busy) begin
                    state <= eerd_pkg::S_IDLE;
                    sda_oe <= 1'b0;
                  end else begin
                    ack_next <= shreg[0] ? eerd_pkg::S_RDAT : eerd_pkg::S_AHI;
                  end
                end
                eerd_pkg::S_AHI: begin
                  addr_hi <= shreg[4:0];
                  ack_next <= eerd_pkg::S_ALO;
                end
                eerd_pkg::S_ALO: begin
                  word_addr <= {addr_hi, shreg};
                  page_row <= {addr_hi, shreg[7:5]};
                  pmask <= '0;
                  ack_next <= eerd_pkg::S_WDAT;
                end
                default: begin
                  // data always acked, even into a protected page
                  pbuf[word_addr[4:0]] <= shreg;
                  pmask[word_addr[4:0]] <= 1'b1;
                  word_addr[4:0] <= word_addr[4:0] + 5'h01;
                  pend <= 1'b1;
                  ack_next <= eerd_pkg::S_WDAT;
                end
              endcase
            end
          end
          eerd_pkg::S_ACK: begin
            if (scl_fall) begin
              if (ack_next == eerd_pkg::S_RDAT) begin
                shreg <= rd_word;
                sda_oe <= ~rd_word[7];
                word_addr <= word_addr + eerd_pkg::ADDR_ONE;
                bit_cnt <= 4'h1;
                state <= eerd_pkg::S_RDAT;
              end else begin
                sda_oe <= 1'b0;
                state <= ack_next;
              end
            end
          end
          eerd_pkg::S_RDAT: begin
            if (scl_fall) begin
              if (bit_cnt == eerd_pkg::BYTE_BITS) begin
                sda_oe <= 1'b0;
                state <= eerd_pkg::S_MACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          eerd_pkg::S_MACK: begin
            if (scl_rise && sda_s) begin
              state <= eerd_pkg::S_IDLE;
            end else if (scl_fall) begin
              shreg <= rd_word;
              sda_oe <= ~rd_word[7];
              word_addr <= word_addr + eerd_pkg::ADDR_ONE;
              bit_cnt <= 4'h1;
              state <= eerd_pkg::S_RDAT;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // array: buffered page bytes land at the stop, hidden behind the busy window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < eerd_pkg::MEM_BYTES; i++) begin
        mem[i] <= eerd_pkg::ERASED;
      end
    end else if (commit) begin
      for (int i = 0; i < eerd_pkg::PAGE_BYTES; i++) begin
        if (pmask[i]) begin
          mem[{page_row, 5'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // self-timed write cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= '0;
      write_busy <= 1'b0;
    end else if (ce) begin
      if (commit) begin
        wr_cnt <= eerd_pkg::WR_CNT_W'(WRITE_CYCLES);
        write_busy <= 1'b1;
      end else if (wr_cnt != '0) begin
        wr_cnt <= wr_cnt - eerd_pkg::WR_CNT_ONE;
        write_busy <= wr_cnt > eerd_pkg::WR_CNT_ONE;
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_busy_nack;
    state == eerd_pkg::S_DEV && byte_end && write_busy |=> !sda_oe && state == eerd_pkg::S_IDLE;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

  property p_stop_starts_busy;
    commit |=> write_busy && wr_cnt == eerd_pkg::WR_CNT_W'(WRITE_CYCLES);
  endproperty
  a_stop_starts_busy: assert property (p_stop_starts_busy) else $error("no write cycle");

  property p_prot_block;
    stop_c && pend && wp_s && in_upper(page_row) |=> !write_busy;
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("protected write ran");

  property p_unprot;
    stop_c && pend && !wp_s |=> write_busy;
  endproperty
  a_unprot: assert property (p_unprot) else $error("unprotected write lost");

  property p_cycle_holds;
    $rose(write_busy) |=> write_busy [*8];
  endproperty
  a_cycle_holds: assert property (p_cycle_holds) else $error("write cycle cut short");

  property p_prot_ack;
    state == eerd_pkg::S_WDAT && byte_end |=> sda_oe && state == eerd_pkg::S_ACK;
  endproperty
  a_prot_ack: assert property (p_prot_ack) else $error("data byte not acked");

  property p_lower_writes;
    stop_c && pend && !in_upper(page_row) |=> write_busy;
  endproperty
  a_lower_writes: assert property (p_lower_writes) else $error("lower write blocked");

  property p_incr;
    load_ev |=> word_addr == AW'($past(word_addr) + eerd_pkg::ADDR_ONE);
  endproperty
  a_incr: assert property (p_incr) else $error("counter not advanced");

  property p_wrap;
    load_ev && (&word_addr) |=> word_addr == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_read_byte;
    load_ev |=> shreg == $past(rd_word) && sda_oe == !$past(rd_word[7]);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("wrong read byte");

  property p_nack_ends;
    state == eerd_pkg::S_MACK && scl_rise && sda_s && !start_c && !stop_c
      |=> state == eerd_pkg::S_IDLE && !sda_oe;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("read not ended");

  property p_dev_mismatch;
    state == eerd_pkg::S_DEV && byte_end && !addr_match(shreg, strap_s) |=> !sda_oe;
  endproperty
  a_dev_mismatch: assert property (p_dev_mismatch) else $error("foreign address acked");

  property p_word_addr;
    state == eerd_pkg::S_ALO && byte_end |=> word_addr == {$past(addr_hi), $past(shreg)};
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("word address wrong");
endmodule

// ===== src/eerd_pkg.sv
// shared constants and types for the serial eeprom access block
package eerd_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  localparam logic [3:0] DEV_TYPE = 4'b1010;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PROT_QUAD = 2'b11;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
  // self_timed_write_duration as a longest time, rounded down to cycles
  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_CYCLES = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 18;
  localparam logic [WR_CNT_W-1:0] WR_CNT_ONE = 18'h0_0001;
  typedef enum logic [3:0] {
    S_IDLE, S_DEV, S_AHI, S_ALO, S_WDAT, S_ACK, S_RDAT, S_MACK
  } eerd_state_t;
endpackage

// ===== src/eerd_sync.sv
// three-stage pin synchroniser with second/third stage agreement
module eerd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // pin side
  input wire logic [W-1:0] pin,
  // clean level
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit only moves once two settled stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_agree
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          level[g] <= INIT[g];
        end else if (ce && (s2[g] == s3[g])) begin
          level[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule

// ===== testbench/eerd_master.sv
// behavioural two-wire bus master that drives the eeprom block
module eerd_master (
  // clock
  input wire logic ref_clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  // observed results
  output logic got,
  output logic [7:0] got_val
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
    got_val = 8'h00;
  end
  // 8 cycles a phase, above the 6 the block needs
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #2;
  endtask
  task automatic emit(input logic [7:0] v);
    got_val = v;
    got = 1'b1;
    @(posedge ref_clk);
    #2;
    got = 1'b0;
  endtask
  task automatic bitx(input logic b, output logic r);
    // data moves two cycles after the clock fall, never with it
    repeat (2) @(posedge ref_clk);
    #2;
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  // also serves as the repeated start after a dummy write
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
    end
    bitx(1'b1, r);
    emit({7'h00, !r});
  endtask
  // ack keeps a sequential read going, nack ends it
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
    emit(d);
  endtask
endmodule

// ===== testbench/tb_eerd_top.sv
// self-checking bench for the eeprom access block
module tb_eerd_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 400;
  logic ref_clk;
  logic rst_n;
  logic wp_in;
  logic [2:0] strap;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  logic scl;
  logic sda_low;
  logic got;
  logic [7:0] got_val;
  logic [7:0] mem [0:8191];
  logic [12:0] ctr;
  logic [7:0] expq [$];
  int mismatches;
  int n_checks;
  int cycles;
  // pulled up unless someone pulls low
  wire logic sda = !((sda_oe && !sda_out) || sda_low);
  eerd_top #(.WRITE_CYCLES(WCYC)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap(strap), .wp_in(wp_in), .write_busy(write_busy)
  );
  eerd_master u_master (
    .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .got(got), .got_val(got_val)
  );
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge got) begin
    if (expq.size() == 0) begin
      mismatches++;
      $display("CHECK FAILED at %0t: unexpected result", $time);
    end else begin
      chk(got_val, expq.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic send(input logic [7:0] b, input logic a);
    expq.push_back({7'h00, a});
    u_master.wbyte(b);
  endtask
  task automatic addr(input logic [12:0] a);
    u_master.start();
    send({4'b1010, strap, 1'b0}, 1'b1);
    send({3'($urandom), a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask
  // dummy write first unless cur, then n bytes with the last one nacked
  task automatic rd(input logic cur, input logic [12:0] a, input int n);
    if (!cur) begin
      addr(a);
      ctr = a;
    end
    u_master.start();
    send({4'b1010, strap, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      expq.push_back(mem[ctr]);
      ctr = ctr + 13'h0001;
      u_master.rbyte(i == n - 1);
    end
    repeat (6) @(posedge ref_clk);
    // look off the edge, after the drive has settled
    #2;
    chk({7'h00, sda_oe}, 8'h00);
    u_master.stop();
  endtask
  task automatic wr(input logic [12:0] a, input int n, input logic wpn);
    logic [7:0] d;
    logic prot;
    prot = wp_in === 1'b1 && a[12:11] == 2'b11;
    addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (!prot) begin
        mem[{a[12:5], 5'(a[4:0] + i)}] = d;
      end
      send(d, 1'b1);
    end
    u_master.stop();
    // protect moves after its capture at stop
    wp_in = wpn;
    chk({7'h00, write_busy}, {7'h00, !prot});
    if (!prot) begin
      ctr = {a[12:5], 5'(a[4:0] + n)};
    end
    u_master.start();
    send({4'b1010, strap, 1'b0}, prot);
    u_master.stop();
    for (int i = 0; i < 2000 && write_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
    end
    #2;
  endtask
  initial begin
    rst_n = 1'b0;
    wp_in = 1'b0;
    strap = 3'b000;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    ctr = 13'h0000;
    void'($urandom(31840));
    strap = 3'($urandom);
    for (int i = 0; i < 8192; i++) begin
      mem[i] = eerd_pkg::ERASED;
    end
    repeat (4) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #2;
    u_master.start();
    send({4'b1011, strap, 1'b0}, 1'b0);
    u_master.start();
    send({4'b1010, ~strap, 1'b1}, 1'b0);
    u_master.stop();
    wp_in = 1'b1;
    rd(1'b1, 13'h0000, 2);
    wr(13'h015E, 4, 1'b1);
    rd(1'b1, 13'h0000, 1);
    rd(1'b0, 13'h015E, 2);
    rd(1'b0, 13'h0140, 3);
    wr(13'h1805, 2, 1'b0);
    rd(1'b0, 13'h1805, 2);
    wr(13'h1FFE, 2, 1'b1);
    rd(1'b0, 13'h1FFE, 4);
    rd(1'b1, 13'h0000, 1);
    give_verdict();
  end
endmodule
